// ---- diag_pkg.sv ----
// Constants, types and register map for the LED driver diagnostic instruction unit
package diag_pkg;

	// Pulse counts on the serial input while the frame strobe is high
	localparam logic [4:0] CNT_OPEN = 5'h02;
	localparam logic [4:0] CNT_SHORT = 5'h04;
	localparam logic [4:0] CNT_GND = 5'h06;
	localparam logic [4:0] CNT_THERM = 5'h08;
	localparam logic [4:0] CNT_SMART = 5'h0A;
	localparam logic [4:0] CNT_SLEEP = 5'h0C;
	localparam logic [4:0] CNT_BIAS = 5'h0E;
	localparam logic [4:0] CNT_MAX = 5'h1F;

	// Register byte offsets (low address bits only)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SHIFT = 8'h08;

	// Control fields and reset values
	localparam int CTRL_WD_BIT = 0;
	localparam int CTRL_THR_LSB = 2;
	localparam logic CTRL_WD_RST = 1'b0;
	localparam logic [1:0] CTRL_THR_RST = 2'b00;

	// Status fields
	localparam int STAT_SLEEP_BIT = 0;
	localparam int STAT_WDF_BIT = 1;
	localparam int STAT_WAIT_BIT = 2;
	localparam int STAT_MODE_LSB = 4;

	// Grayscale clock watchdog timeout
	localparam int WD_TIMEOUT_MS = 30;
	localparam int CLK_MHZ = 100;
	localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_MHZ * 1000;

	typedef enum logic [2:0]
	{
		MODE_DATA = 3'b000,
		MODE_OPEN = 3'b001,
		MODE_SHORT = 3'b010,
		MODE_GND = 3'b011,
		MODE_THERM = 3'b100,
		MODE_SMART = 3'b101,
		MODE_SLEEP = 3'b110,
		MODE_BIAS = 3'b111
	} mode_t;

	typedef enum logic [0:0]
	{
		DET_IDLE = 1'b0,
		DET_WAIT = 1'b1
	} det_t;

	// Comparator flags from the analog front end, one per channel plus chip-wide
	typedef struct packed
	{
		logic [15:0] below_low;
		logic [15:0] above_short;
		logic hot;
		logic bias_fault;
	} sense_t;

endpackage

// ---- led_diag_unit.sv ----
// Diagnostic and sleep instruction decoder with serial result shift-out and AHB-Lite control
//
// Operation
// - Two pulses start LED open detection regardless of image data, strobed at fall.
// - Four pulses start LED short detection regardless of image data, strobed at fall.
// - Six pulses start short-to-ground check on every sink pin.
// - During short-to-ground check all sinks are forced off.
// - Eight pulses load thermal result at bit 16, watchdog at bit 1, ones elsewhere.
// - Ten pulses run open and short checks together per channel.
// - Twelve pulses sleep at that strobe fall; next strobe fall wakes.
// - Serial interface keeps accepting and shifting data during sleep.
// - Fourteen pulses load bias-resistor result at bit 16, watchdog at bit 1.
// - Result bit zero means fault, one means normal.
// - Open, short and smart checks switch every sink to the small test current.
// - Detection interval spans strobe fall to next shift-clock rise.
// - Open and short-to-ground checks load zero where pin is below low threshold.
// - Short and smart checks load zero where pin exceeds selected short threshold.
// - Results shift out on serial output at each shift-clock rise.
// - While strobe high, serial output is a retimed copy of serial input.
// - Watchdog bit is zero when enabled and grayscale clock stalled past timeout.
// - Thermal bit is zero when the sensor flags pre-warning temperature.
// - Bias bit is zero when its comparators flag open, high or low.
// - Short threshold select field resets to 2'b00, four levels.
// - Image data shifts through 16-bit register, most significant bit first.
// - Watchdog enable resets to zero; when set, a stalled clock turns outputs off.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module led_diag_unit
	import diag_pkg::*;
#(
	parameter int unsigned WD_CYC = WD_TIMEOUT_CYC
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic FRAME_STROBE,
	input wire logic SHIFT_CLOCK,
	input wire logic SERIAL_IN,
	input wire logic GRAYSCALE_CLOCK,
	input wire sense_t SENSE,
	output logic SERIAL_OUT,
	output logic TEST_CURRENT,
	output logic SINK_FORCE_OFF,
	output logic [1:0] SHORT_THRESHOLD,
	output logic SLEEP
);

	function automatic mode_t decode_count(input logic [4:0] n);
		mode_t m;
		case (n)
			CNT_OPEN: m = MODE_OPEN;
			CNT_SHORT: m = MODE_SHORT;
			CNT_GND: m = MODE_GND;
			CNT_THERM: m = MODE_THERM;
			CNT_SMART: m = MODE_SMART;
			CNT_SLEEP: m = MODE_SLEEP;
			CNT_BIAS: m = MODE_BIAS;
			default: m = MODE_DATA;
		endcase
		return m;
	endfunction

	// Two-stage synchronisers; the first stage feeds only the second
	logic [3:0] pin_m_r;
	logic [3:0] pin_s_r;
	logic [3:0] pin_d_r;
	sense_t sense_m_r;
	sense_t sense_s_r;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pin_m_r <= 4'h0;
			pin_s_r <= 4'h0;
			pin_d_r <= 4'h0;
			sense_m_r <= '0;
			sense_s_r <= '0;
		end
		else
		begin
			pin_m_r <= {GRAYSCALE_CLOCK, SERIAL_IN, SHIFT_CLOCK, FRAME_STROBE};
			pin_s_r <= pin_m_r;
			pin_d_r <= pin_s_r;
			sense_m_r <= SENSE;
			sense_s_r <= sense_m_r;
		end
	end

	wire strobe_hi = pin_s_r[0];
	wire st_fall = pin_d_r[0] & ~pin_s_r[0];
	wire sck_rise = pin_s_r[1] & ~pin_d_r[1];
	wire si_s = pin_s_r[2];
	wire si_rise = pin_s_r[2] & ~pin_d_r[2];
	wire gck_edge = pin_s_r[3] ^ pin_d_r[3];

	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	mode_t mode_r;
	mode_t mode_nxt;
	mode_t new_mode;
	det_t det_r;
	det_t det_nxt;
	logic [15:0] sr_r;
	logic [15:0] sr_nxt;
	logic [15:0] img_r;
	logic sleep_r;
	logic sleep_nxt;
	logic test_r;
	logic force_r;
	logic so_r;
	logic wd_en_r;
	logic [1:0] thr_r;
	logic [31:0] wd_cnt_r;
	logic wd_fault_r;

	// Counter saturates so that a runaway burst cannot wrap onto a valid instruction
	assign cnt_nxt = st_fall ? 5'h00 :
		(strobe_hi && si_rise && cnt_r != CNT_MAX) ? cnt_r + 5'h01 : cnt_r;
	assign new_mode = decode_count(cnt_r);

	wire is_detect = (new_mode == MODE_OPEN) || (new_mode == MODE_SHORT) ||
		(new_mode == MODE_GND) || (new_mode == MODE_SMART);
	wire is_readout = (new_mode == MODE_THERM) || (new_mode == MODE_BIAS);

	assign mode_nxt = st_fall ? new_mode : mode_r;

	always_comb
	begin
		det_nxt = det_r;
		case (det_r)
			DET_IDLE:
				if (st_fall && is_detect)
					det_nxt = DET_WAIT;
			DET_WAIT:
				if (st_fall)
					det_nxt = is_detect ? DET_WAIT : DET_IDLE;
				else if (sck_rise)
					det_nxt = DET_IDLE;
			default:
				det_nxt = DET_IDLE;
		endcase
	end

	// Channel results, zero marks a fault
	wire [15:0] open_ok = ~sense_s_r.below_low;
	wire [15:0] short_ok = ~sense_s_r.above_short;
	wire [15:0] chan_res = (mode_r == MODE_SHORT) ? short_ok :
		(mode_r == MODE_SMART) ? (open_ok & short_ok) : open_ok;
	wire wd_ok = ~wd_fault_r;
	wire [13:0] ones_fill = 14'h3FFF;
	wire [15:0] therm_res = {~sense_s_r.hot, ones_fill, wd_ok};
	wire [15:0] bias_res = {~sense_s_r.bias_fault, ones_fill, wd_ok};

	// Channel results are captured at the end of the detection interval, thermal and bias words at the strobe fall, then shift as image data
	assign sr_nxt = (st_fall && new_mode == MODE_THERM) ? therm_res :
		(st_fall && new_mode == MODE_BIAS) ? bias_res :
		(sck_rise && det_r == DET_WAIT && !st_fall) ? chan_res :
		sck_rise ? {sr_r[14:0], si_s} : sr_r;

	assign sleep_nxt = st_fall ? (new_mode == MODE_SLEEP) : sleep_r;

	wire testing_nxt = (det_nxt == DET_WAIT) && (mode_nxt != MODE_GND);
	wire force_nxt = ((det_nxt == DET_WAIT) && (mode_nxt == MODE_GND)) || wd_fault_r;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cnt_r <= 5'h00;
			mode_r <= MODE_DATA;
			det_r <= DET_IDLE;
			sr_r <= 16'h0000;
			sleep_r <= 1'b0;
			test_r <= 1'b0;
			force_r <= 1'b0;
			so_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			mode_r <= mode_nxt;
			det_r <= det_nxt;
			sr_r <= sr_nxt;
			sleep_r <= sleep_nxt;
			test_r <= testing_nxt;
			force_r <= force_nxt;
			so_r <= strobe_hi ? si_s : sr_r[15];
		end
	end

	// Plain data latches keep a copy of the shift register for readback
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			img_r <= 16'h0000;
		else if (st_fall && new_mode == MODE_DATA)
			img_r <= sr_r;
	end

	// Watchdog runs in sleep too, so a host that holds the clock high trips it if enabled
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wd_cnt_r <= 32'h00000000;
			wd_fault_r <= 1'b0;
		end
		else
		begin
			if (gck_edge)
				wd_cnt_r <= 32'h00000000;
			else if (wd_cnt_r < WD_CYC)
				wd_cnt_r <= wd_cnt_r + 32'h00000001;
			wd_fault_r <= wd_en_r && !gck_edge && (wd_cnt_r >= WD_CYC);
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	logic ap_wr_r;
	logic [7:0] ap_addr_r;
	logic [31:0] rdata_r;
	wire ap_take = HSEL && HREADY && HTRANS[1];
	wire [7:0] ap_addr = HADDR[7:0];
	wire [31:0] status_word = {24'h000000, 1'b0, mode_r, 1'b0, (det_r == DET_WAIT), wd_fault_r, sleep_r};
	wire [31:0] ctrl_word = {28'h0000000, thr_r, 1'b0, wd_en_r};
	wire [31:0] rd_mux = (ap_addr == OFS_CTRL) ? ctrl_word :
		(ap_addr == OFS_STATUS) ? status_word :
		(ap_addr == OFS_SHIFT) ? {img_r, sr_r} : 32'h00000000;
	wire ctrl_we = ap_wr_r && (ap_addr_r == OFS_CTRL);

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= 8'h00;
			rdata_r <= 32'h00000000;
			wd_en_r <= CTRL_WD_RST;
			thr_r <= CTRL_THR_RST;
		end
		else
		begin
			ap_wr_r <= ap_take && HWRITE;
			ap_addr_r <= ap_addr;
			rdata_r <= (ap_take && !HWRITE) ? rd_mux : 32'h00000000;
			if (ctrl_we)
			begin
				wd_en_r <= HWDATA[CTRL_WD_BIT];
				thr_r <= HWDATA[CTRL_THR_LSB+1:CTRL_THR_LSB];
			end
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = rdata_r;
	assign SERIAL_OUT = so_r;
	assign TEST_CURRENT = test_r;
	assign SINK_FORCE_OFF = force_r;
	assign SHORT_THRESHOLD = thr_r;
	assign SLEEP = sleep_r;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_fall_cnt(logic [4:0] n);
		st_fall && cnt_r == n;
	endsequence

	sequence s_wait_open;
		det_r == DET_WAIT && mode_r != MODE_GND;
	endsequence

	sequence s_load(mode_t m);
		det_r == DET_WAIT && mode_r == m && sck_rise && !st_fall;
	endsequence

	data_latch_a: assert property (st_fall && decode_count(cnt_r) == MODE_DATA |=> det_r == DET_IDLE && !SLEEP)
		else $error("Unlisted count started an instruction");
	open_start_a: assert property (s_fall_cnt(CNT_OPEN) |=> mode_r == MODE_OPEN ##1 TEST_CURRENT)
		else $error("Open detection did not start");
	short_start_a: assert property (s_fall_cnt(CNT_SHORT) |=> mode_r == MODE_SHORT && det_r == DET_WAIT)
		else $error("Short detection did not start");
	gnd_force_a: assert property (s_fall_cnt(CNT_GND) |=> ##1 SINK_FORCE_OFF && !TEST_CURRENT)
		else $error("Sinks not forced off for ground check");
	therm_load_a: assert property (s_fall_cnt(CNT_THERM) |=> sr_r[14:1] == 14'h3FFF && sr_r[15] == !$past(sense_s_r.hot) && sr_r[0] == $past(wd_ok))
		else $error("Thermal readout word wrong");
	bias_load_a: assert property (s_fall_cnt(CNT_BIAS) |=> sr_r == {!$past(sense_s_r.bias_fault), 14'h3FFF, $past(wd_ok)})
		else $error("Bias readout word wrong");
	smart_res_a: assert property (s_wait_open and (mode_r == MODE_SMART && sck_rise && !st_fall) |=> sr_r == ~($past(sense_s_r.below_low) | $past(sense_s_r.above_short)))
		else $error("Smart result wrong");
	sleep_enter_a: assert property (s_fall_cnt(CNT_SLEEP) |=> SLEEP)
		else $error("Sleep not entered");
	sleep_wake_a: assert property (SLEEP && st_fall && cnt_r != CNT_SLEEP |=> !SLEEP)
		else $error("Sleep not left at next strobe fall");
	retime_out_a: assert property (strobe_hi |=> SERIAL_OUT == $past(si_s))
		else $error("Serial output not a copy of input");
	shift_step_a: assert property (sck_rise && !st_fall && det_r == DET_IDLE |=> sr_r == {$past(sr_r[14:0]), $past(si_s)})
		else $error("Shift register did not advance");
	wd_trip_a: assert property (wd_en_r && !gck_edge && wd_cnt_r >= WD_CYC && !ctrl_we |=> wd_fault_r ##1 SINK_FORCE_OFF)
		else $error("Watchdog did not trip");

	// Channel results land on the first shift-clock rise after the strobe falls
	open_res_a: assert property (s_load(MODE_OPEN) |=> sr_r == ~$past(sense_s_r.below_low))
		else $error("Open result wrong");
	short_res_a: assert property (s_load(MODE_SHORT) |=> sr_r == ~$past(sense_s_r.above_short))
		else $error("Short result wrong");
	gnd_res_a: assert property (s_load(MODE_GND) |=> sr_r == ~$past(sense_s_r.below_low))
		else $error("Ground check result wrong");
	test_end_a: assert property (det_r == DET_WAIT && sck_rise && !st_fall |=> !TEST_CURRENT)
		else $error("Test current outlived the interval");
	short_test_a: assert property (s_fall_cnt(CNT_SHORT) |=> ##1 TEST_CURRENT)
		else $error("Short check without test current");
	smart_test_a: assert property (s_fall_cnt(CNT_SMART) |=> ##1 TEST_CURRENT)
		else $error("Smart check without test current");
	therm_mode_a: assert property (s_fall_cnt(CNT_THERM) |=> mode_r == MODE_THERM && det_r == DET_IDLE)
		else $error("Thermal readout mode wrong");
	bias_mode_a: assert property (s_fall_cnt(CNT_BIAS) |=> mode_r == MODE_BIAS && det_r == DET_IDLE)
		else $error("Bias readout mode wrong");

	// Sleep keeps the serial path alive until the next strobe fall
	sleep_hold_a: assert property (SLEEP && !st_fall |=> SLEEP)
		else $error("Sleep left without strobe fall");
	sleep_shift_a: assert property (SLEEP && sck_rise && !st_fall && det_r == DET_IDLE |=> sr_r[0] == $past(si_s))
		else $error("Shift stalled during sleep");
	cnt_sat_a: assert property (cnt_r == CNT_MAX && !st_fall |=> cnt_r == CNT_MAX)
		else $error("Pulse counter wrapped");
	thr_write_a: assert property (ctrl_we |=> SHORT_THRESHOLD == $past(HWDATA[CTRL_THR_LSB+1:CTRL_THR_LSB]))
		else $error("Threshold field not stored");
	wd_quiet_a: assert property (!wd_en_r |=> !wd_fault_r)
		else $error("Watchdog tripped while disabled");
	wd_clear_a: assert property (gck_edge |=> !wd_fault_r)
		else $error("Watchdog fault held after clock edge");

endmodule

// ---- host_link_model.sv ----
// Host controller model driving the serial strobe, shift clock and data pins
`timescale 1ns/1ns
module host_link_model
(
	output logic FRAME_STROBE,
	output logic SHIFT_CLOCK,
	output logic SERIAL_IN,
	input wire logic SERIAL_OUT
);
	int copy_bad = 0;
	initial
	begin
		FRAME_STROBE = 1'b0;
		SHIFT_CLOCK = 1'b0;
		SERIAL_IN = 1'b0;
	end
	// Shift clock stands low between frames; one period is 125 ns
	task automatic pulse;
		#62;
		SHIFT_CLOCK <= 1'b1;
		#63;
		SHIFT_CLOCK <= 1'b0;
	endtask
	task automatic instr(input int n);
		FRAME_STROBE <= 1'b1;
		#125;
		repeat (n)
		begin
			SERIAL_IN <= 1'b1;
			#62;
			if (SERIAL_OUT !== 1'b1) copy_bad++;
			SERIAL_IN <= 1'b0;
			#63;
			if (SERIAL_OUT !== 1'b0) copy_bad++;
		end
		FRAME_STROBE <= 1'b0;
		// Leave the detection gap before any shift clock
		#250;
	endtask
	// Sample the output bit before each of the 16 data rises, after any load rise, most significant first
	task automatic shift(input logic ld, input logic [15:0] din, output logic [15:0] dout);
		if (ld) pulse();
		for (int i = 15; i >= 0; i--)
		begin
			dout[i] = SERIAL_OUT;
			SERIAL_IN <= din[i];
			pulse();
		end
		SERIAL_IN <= 1'b0;
	endtask
endmodule

// ---- tb_top.sv ----
// Top-level bench for the diagnostic instruction unit
`timescale 1ns/1ns
module tb_top
	import diag_pkg::*;
;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'b00;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA, rd;
	logic HREADYOUT, HRESP, SERIAL_OUT, TEST_CURRENT, SINK_FORCE_OFF, SLEEP;
	logic [1:0] SHORT_THRESHOLD;
	logic FRAME_STROBE, SHIFT_CLOCK, SERIAL_IN;
	logic GRAYSCALE_CLOCK = 1'b0;
	logic gck_run = 1'b1;
	sense_t SENSE = '0;
	logic [15:0] res;
	int failures = 0;
	int samples_checked = 0;
	always #5 CLK = ~CLK;
	always #40 if (gck_run) GRAYSCALE_CLOCK <= ~GRAYSCALE_CLOCK;
	led_diag_unit #(.WD_CYC(50)) led_diag_unit_inst
	(
		.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
		.HRESP(HRESP), .FRAME_STROBE(FRAME_STROBE), .SHIFT_CLOCK(SHIFT_CLOCK), .SERIAL_IN(SERIAL_IN),
		.GRAYSCALE_CLOCK(GRAYSCALE_CLOCK), .SENSE(SENSE), .SERIAL_OUT(SERIAL_OUT),
		.TEST_CURRENT(TEST_CURRENT), .SINK_FORCE_OFF(SINK_FORCE_OFF),
		.SHORT_THRESHOLD(SHORT_THRESHOLD), .SLEEP(SLEEP)
	);
	host_link_model host_link_model_inst
	(
		.FRAME_STROBE(FRAME_STROBE), .SHIFT_CLOCK(SHIFT_CLOCK), .SERIAL_IN(SERIAL_IN),
		.SERIAL_OUT(SERIAL_OUT)
	);
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Single word transfer; hready is waited for, never assumed
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {24'h0, a};
		HWRITE <= wr;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rdv = HRDATA;
	endtask
	task automatic diag(input int n, input mode_t m, input logic ld, input logic [15:0] exp);
		host_link_model_inst.instr(n);
		ahb(1'b0, OFS_STATUS, 32'h0, rd);
		chk("mode", m, rd[STAT_MODE_LSB +: 3]);
		if (ld)
		begin
			chk("test_current", m != MODE_GND, TEST_CURRENT);
			chk("force_off", m == MODE_GND, SINK_FORCE_OFF);
			chk("interval", 1, rd[STAT_WAIT_BIT]);
		end
		host_link_model_inst.shift(ld, 16'h0000, res);
		chk("result", exp, res);
		chk("test_current_end", 0, TEST_CURRENT);
		$display("instruction %0d done", n);
	endtask
	initial
	begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		ahb(1'b0, OFS_CTRL, 32'h0, rd);
		chk("ctrl_reset", 0, rd);
		chk("hresp", 0, HRESP);
		ahb(1'b1, OFS_STATUS, 32'hFFFFFFFF, rd);
		ahb(1'b0, OFS_STATUS, 32'h0, rd);
		chk("status_ro", 0, rd);
		ahb(1'b0, 8'hFC, 32'h0, rd);
		chk("unmapped", 0, rd);
		for (int t = 0; t < 4; t++)
		begin
			ahb(1'b1, OFS_CTRL, t << CTRL_THR_LSB, rd);
			repeat (2) @(posedge CLK);
			chk("threshold", t, SHORT_THRESHOLD);
		end
		$display("register test done");
		SENSE <= '{16'hA5C3, 16'h0F18, 1'b0, 1'b1};
		diag(CNT_OPEN, MODE_OPEN, 1'b1, 16'h5A3C);
		diag(CNT_SHORT, MODE_SHORT, 1'b1, 16'hF0E7);
		diag(CNT_GND, MODE_GND, 1'b1, 16'h5A3C);
		diag(CNT_SMART, MODE_SMART, 1'b1, 16'h5024);
		diag(CNT_BIAS, MODE_BIAS, 1'b0, 16'h7FFF);
		SENSE.hot <= 1'b1;
		SENSE.bias_fault <= 1'b0;
		ahb(1'b1, OFS_CTRL, 32'h1, rd);
		gck_run <= 1'b0;
		repeat (100) @(posedge CLK);
		chk("wd_off", 1, SINK_FORCE_OFF);
		diag(CNT_THERM, MODE_THERM, 1'b0, 16'h7FFE);
		gck_run <= 1'b1;
		repeat (20) @(posedge CLK);
		chk("wd_clear", 0, SINK_FORCE_OFF);
		ahb(1'b1, OFS_CTRL, 32'h0, rd);
		gck_run <= 1'b0;
		GRAYSCALE_CLOCK <= 1'b1;
		host_link_model_inst.instr(CNT_SLEEP);
		chk("sleep", 1, SLEEP);
		host_link_model_inst.shift(1'b0, 16'h3C96, res);
		ahb(1'b0, OFS_SHIFT, 32'h0, rd);
		chk("shift_in", 16'h3C96, rd[15:0]);
		host_link_model_inst.instr(3);
		chk("wake", 0, SLEEP);
		ahb(1'b0, OFS_STATUS, 32'h0, rd);
		chk("plain_latch", MODE_DATA, rd[STAT_MODE_LSB +: 3]);
		host_link_model_inst.shift(1'b0, 16'h0000, res);
		chk("shift_out", 16'h3C96, res);
		chk("retime", 0, host_link_model_inst.copy_bad);
		gck_run <= 1'b1;
		$display("sleep test done");
		tally_and_finish();
	end
	initial
	begin
		#500000;
		failures++;
		tally_and_finish();
	end
endmodule
